// ### hw/status_bank_pkg.sv
// Package with offsets, field positions and types of the charger status readback bank.
`default_nettype none
package status_bank_pkg;
   localparam logic [7:0] OFS_OPT_THERM_DET = 8'h1d;
   localparam logic [7:0] OFS_PATH_CONV_TMR = 8'h1e;
   localparam logic [7:0] OFS_TEMP_ZONE     = 8'h1f;
   localparam logic [7:0] RESET_STATUS      = 8'h00;
   localparam int         POS_OPT_STATE     = 6;
   localparam int         POS_DIE_THERMAL   = 2;
   localparam int         POS_DATA_LINE     = 1;
   localparam int         POS_BAT_PRESENT   = 0;
   localparam int         POS_SECOND_PATH   = 7;
   localparam int         POS_FIRST_PATH    = 6;
   localparam int         POS_CONV_DONE     = 5;
   localparam int         POS_SYS_MIN       = 4;
   localparam int         POS_FAST_TMO      = 3;
   localparam int         POS_TRICKLE_TMO   = 2;
   localparam int         POS_PRE_TMO       = 1;
   localparam int         POS_BAT_LOW_BOOST = 4;
   localparam int         POS_COLD          = 3;
   localparam int         POS_COOL          = 2;
   localparam int         POS_WARM          = 1;
   localparam int         POS_HOT           = 0;

   // Optimizer progress codes.
   typedef enum logic [1:0] {
      OPT_DISABLED = 2'b00,
      OPT_RUNNING  = 2'b01,
      OPT_FOUND    = 2'b10,
      OPT_RESERVED = 2'b11
   } opt_state_type;

   // Live internal conditions feeding the bank.
   typedef struct packed {
      opt_state_type current_optimizer_state;
      logic          die_thermal_regulation_bit;
      logic          data_line_detect_active;
      logic          battery_above_release;
      logic          second_input_path_fitted;
      logic          first_input_path_fitted;
      logic          one_shot_mode;
      logic          conversion_finished;
      logic          forward_mode;
      logic          battery_below_minimum;
      logic          fast_charge_timeout_bit;
      logic          trickle_timeout_bit;
      logic          precharge_timeout_bit;
      logic          battery_low_for_reverse_boost;
      logic          thermistor_cold_zone;
      logic          thermistor_cool_zone;
      logic          thermistor_warm_zone;
      logic          thermistor_hot_zone;
   } condition_type;
endpackage
`default_nettype wire

// ### hw/status_sync.sv
// Two-flop synchroniser for a vector of asynchronous condition levels.
`default_nettype none
module status_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] async_in,
   output var  logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_r;

   // First stage feeds only the second stage.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_r   <= '0;
         sync_out <= '0;
      end else begin
         meta_r   <= async_in;
         sync_out <= meta_r;
      end
   end
endmodule
`default_nettype wire

// ### hw/charger_status_readback_bank.sv
// Read-only charger status bank at offsets 1d to 1f, fed by live conditions.
`default_nettype none
module charger_status_readback_bank
   import status_bank_pkg::*;
(
   input  wire logic          CLK,
   input  wire logic          RST,
   input  wire condition_type COND,
   input  wire logic [7:0]    RD_ADDR,
   input  wire logic          RD_EN,
   input  wire logic          WR_EN,
   input  wire logic [7:0]    WR_DATA,
   output var  logic [7:0]    RD_DATA,
   output var  logic          RD_VALID,
   output var  logic          RD_HIT
);
   condition_type cond_s;
   logic [7:0]    opt_therm_det_r;
   logic [7:0]    opt_therm_det_nxt;
   logic [7:0]    path_conv_tmr_r;
   logic [7:0]    path_conv_tmr_nxt;
   logic [7:0]    temp_zone_r;
   logic [7:0]    temp_zone_nxt;
   logic [7:0]    rd_data_nxt;
   wire           hit_a;
   wire           hit_b;
   wire           hit_c;
   wire           write_ignored;

   // Conditions come from analogue circuits outside this clock domain.
   status_sync #(
      .WIDTH($bits(condition_type))
   ) u_sync (
      .clk      (CLK),
      .rst      (RST),
      .async_in (COND),
      .sync_out (cond_s)
   );

   // Optimizer, thermal, detection and battery presence byte.
   always_comb begin
      opt_therm_det_nxt = RESET_STATUS;
      opt_therm_det_nxt[POS_OPT_STATE+:2] = cond_s.current_optimizer_state;
      opt_therm_det_nxt[POS_DIE_THERMAL]  = cond_s.die_thermal_regulation_bit;
      opt_therm_det_nxt[POS_DATA_LINE]    = cond_s.data_line_detect_active;
      opt_therm_det_nxt[POS_BAT_PRESENT]  = cond_s.battery_above_release;
   end

   // Path placement, conversion, system regulation and timer byte.
   always_comb begin
      path_conv_tmr_nxt = RESET_STATUS;
      path_conv_tmr_nxt[POS_SECOND_PATH] = cond_s.second_input_path_fitted;
      path_conv_tmr_nxt[POS_FIRST_PATH]  = cond_s.first_input_path_fitted;
      path_conv_tmr_nxt[POS_CONV_DONE]   = cond_s.one_shot_mode
                                         & cond_s.conversion_finished;
      path_conv_tmr_nxt[POS_SYS_MIN]     = cond_s.forward_mode
                                         & cond_s.battery_below_minimum;
      path_conv_tmr_nxt[POS_FAST_TMO]    = cond_s.fast_charge_timeout_bit;
      path_conv_tmr_nxt[POS_TRICKLE_TMO] = cond_s.trickle_timeout_bit;
      path_conv_tmr_nxt[POS_PRE_TMO]     = cond_s.precharge_timeout_bit;
   end

   // Reverse boost and thermistor zone byte.
   always_comb begin
      temp_zone_nxt = RESET_STATUS;
      temp_zone_nxt[POS_BAT_LOW_BOOST] = cond_s.battery_low_for_reverse_boost;
      temp_zone_nxt[POS_COLD]          = cond_s.thermistor_cold_zone;
      temp_zone_nxt[POS_COOL]          = cond_s.thermistor_cool_zone;
      temp_zone_nxt[POS_WARM]          = cond_s.thermistor_warm_zone;
      temp_zone_nxt[POS_HOT]           = cond_s.thermistor_hot_zone;
   end

   // Status registers refresh every cycle and never latch.
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         opt_therm_det_r <= RESET_STATUS;
         path_conv_tmr_r <= RESET_STATUS;
         temp_zone_r     <= RESET_STATUS;
      end else begin
         opt_therm_det_r <= opt_therm_det_nxt;
         path_conv_tmr_r <= path_conv_tmr_nxt;
         temp_zone_r     <= temp_zone_nxt;
      end
   end

   // Address decode; writes are accepted and dropped.
   assign hit_a         = (RD_ADDR == OFS_OPT_THERM_DET);
   assign hit_b         = (RD_ADDR == OFS_PATH_CONV_TMR);
   assign hit_c         = (RD_ADDR == OFS_TEMP_ZONE);
   assign write_ignored = WR_EN & (|WR_DATA | 1'b1);
   assign RD_HIT        = RD_EN & (hit_a | hit_b | hit_c);

   // Read mux; unmapped offsets read zero.
   always_comb begin
      rd_data_nxt = RESET_STATUS;
      if (hit_a) begin
         rd_data_nxt = opt_therm_det_r;
      end else if (hit_b) begin
         rd_data_nxt = path_conv_tmr_r;
      end else if (hit_c) begin
         rd_data_nxt = temp_zone_r;
      end
   end

   // Read data is registered one cycle after the strobe; reads have no side effect.
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         RD_DATA  <= RESET_STATUS;
         RD_VALID <= 1'b0;
      end else begin
         RD_VALID <= RD_EN & ~write_ignored;
         if (RD_EN) begin
            RD_DATA <= rd_data_nxt;
         end
      end
   end
endmodule
`default_nettype wire

// ### sim/status_bank_properties.sv
// Concurrent checks on the status bank read port.
`default_nettype none
module status_bank_properties (
   input wire logic       CLK,
   input wire logic       RST,
   input wire logic [7:0] RD_ADDR,
   input wire logic       RD_EN,
   input wire logic       WR_EN,
   input wire logic [7:0] RD_DATA,
   input wire logic       RD_VALID,
   input wire logic       RD_HIT
);
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   // A read strobe aimed at one offset.
   sequence rd_at(logic [7:0] a);
      RD_EN && RD_ADDR == a;
   endsequence
   // Answer timing, decode and the zero bits of each byte.
   chk_read_answer: assert property (RD_EN && !WR_EN |=> RD_VALID)
      else $error("read not answered");
   chk_valid_cause: assert property (RD_VALID |-> $past(RD_EN) && !$past(WR_EN))
      else $error("valid without a plain read");
   chk_hit_decode: assert property (RD_HIT == (RD_EN && RD_ADDR inside {[8'h1d:8'h1f]}))
      else $error("hit decode wrong");
   chk_unmapped_zero: assert property (RD_EN && !RD_HIT |=> RD_DATA == 8'h00)
      else $error("unmapped read not zero");
   chk_spare_first: assert property (rd_at(8'h1d) |=> RD_DATA[5:3] == 3'h0)
      else $error("spare bits set");
   chk_spare_second: assert property (rd_at(8'h1e) |=> !RD_DATA[0])
      else $error("spare bit set");
   chk_spare_third: assert property (rd_at(8'h1f) |=> RD_DATA[7:5] == 3'h0)
      else $error("spare bits set");
   chk_data_holds: assert property (!RD_EN |=> $stable(RD_DATA))
      else $error("read data moved");
endmodule
bind charger_status_readback_bank status_bank_properties status_bank_properties_inst (
   .CLK(CLK), .RST(RST), .RD_ADDR(RD_ADDR), .RD_EN(RD_EN), .WR_EN(WR_EN),
   .RD_DATA(RD_DATA), .RD_VALID(RD_VALID), .RD_HIT(RD_HIT));
`default_nettype wire

// ### sim/status_host.sv
// Host model making byte accesses on the status bank strobe port.
`default_nettype none
module status_host (
   output var  logic       rd_en,
   output var  logic [7:0] rd_addr,
   output var  logic       wr_en,
   output var  logic [7:0] wr_data,
   input  wire logic       clk,
   input  wire logic [7:0] rd_data,
   input  wire logic       rd_valid,
   input  wire logic       rd_hit
);
   timeunit 1ns;
   timeprecision 1ps;
   logic hit;
   initial {rd_en, wr_en, rd_addr, wr_data} = 18'h0;
   // One byte access; released lines show the inverse so stale values never pass.
   task automatic access(input logic [7:0] a, input logic w, output logic [9:0] r);
      @(posedge clk) #1;
      {rd_en, wr_en, rd_addr, wr_data} = {1'b1, w, a, ~a};
      #1 hit = rd_hit;
      @(posedge clk) #1;
      r = {hit, rd_valid, rd_data};
      {rd_en, wr_en, rd_addr, wr_data} = {2'b00, ~a, a};
   endtask
endmodule
`default_nettype wire

// ### sim/testbench.sv
// Self-checking bench for the charger status readback bank.
`default_nettype none
module testbench import status_bank_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic          clk = 1'b0;
   logic          rst = 1'b1;
   condition_type cond = '0;
   logic          rd_en, wr_en, rd_valid, rd_hit;
   logic [7:0]    rd_addr, wr_data, rd_data;
   logic [9:0]    r;
   int            bad_count = 0;
   int            comparisons = 0;
   always #5 clk = ~clk;
   charger_status_readback_bank charger_status_readback_bank_inst (.CLK(clk), .RST(rst),
      .COND(cond), .RD_ADDR(rd_addr), .RD_EN(rd_en), .WR_EN(wr_en), .WR_DATA(wr_data),
      .RD_DATA(rd_data), .RD_VALID(rd_valid), .RD_HIT(rd_hit));
   status_host status_host_inst (.clk(clk), .rd_en(rd_en), .rd_addr(rd_addr), .wr_en(wr_en),
      .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid), .rd_hit(rd_hit));
   // Compares and counts.
   task automatic check(input logic [9:0] seen, input logic [9:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Prints the counts and the verdict, then stops.
   task automatic results();
      $display("mismatches %0d comparisons %0d", bad_count, comparisons);
      if (bad_count == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // Applies conditions and lets them cross the synchroniser.
   task automatic settle(input condition_type c);
      @(posedge clk) #1 cond = c;
      repeat (4) @(posedge clk);
   endtask
   // One access; exp holds hit, valid and data.
   task automatic rd(input logic [7:0] a, input logic w, input logic [9:0] exp);
      status_host_inst.access(a, w, r);
      check(r, exp);
   endtask
   // Reset values and unmapped offsets.
   task automatic reset_reads();
      rd(8'h1d, 1'b0, 10'h300);
      rd(8'h1e, 1'b0, 10'h300);
      rd(8'h1f, 1'b0, 10'h300);
      rd(8'h20, 1'b0, 10'h100);
      rd(8'h1c, 1'b0, 10'h100);
   endtask
   // Every condition raised, a write tried, then the gated bits unqualified.
   task automatic all_raised();
      condition_type c;
      c = '1;
      c.current_optimizer_state = OPT_FOUND;
      settle(c);
      rd(8'h1d, 1'b1, 10'h287);
      rd(8'h1d, 1'b0, 10'h387);
      rd(8'h1e, 1'b0, 10'h3fe);
      rd(8'h1f, 1'b0, 10'h31f);
      c.one_shot_mode = 1'b0;
      c.forward_mode = 1'b0;
      settle(c);
      rd(8'h1e, 1'b0, 10'h3ce);
      c.one_shot_mode = 1'b1;
      c.conversion_finished = 1'b0;
      c.forward_mode = 1'b1;
      c.battery_below_minimum = 1'b0;
      settle(c);
      rd(8'h1e, 1'b0, 10'h3ce);
   endtask
   // Each optimizer code with all else dropped; nothing stays latched.
   task automatic optimizer_codes();
      condition_type c;
      for (int k = 0; k < 4; k++) begin
         c = '0;
         c.current_optimizer_state = opt_state_type'(k[1:0]);
         settle(c);
         rd(8'h1d, 1'b0, {2'b11, k[1:0], 6'h00});
      end
      rd(8'h1e, 1'b0, 10'h300);
      rd(8'h1f, 1'b0, 10'h300);
   endtask
   // Reset, scenarios, verdict.
   initial begin
      repeat (16) @(posedge clk);
      #1 rst = 1'b0;
      reset_reads();
      all_raised();
      optimizer_codes();
      results();
   end
   // Cuts a hang short.
   initial begin
      repeat (5000) @(posedge clk);
      bad_count++;
      results();
   end
endmodule
`default_nettype wire
